// ===== bench/serial_host.sv
`timescale 1ns/1ns

module serial_host (
	input wire logic clock_in,
	output logic serial_clock_out,
	output logic serial_enable_out,
	output logic host_data_out,
	output logic host_oe_n_out,
	input wire logic line_in
);
	logic polarity = 1'b0;
	logic [7:0] read_byte;

	initial begin
		serial_clock_out = 1'b0;
		serial_enable_out = 1'b0;
		host_data_out = 1'b0;
		host_oe_n_out = 1'b1;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clock_in);
	endtask : hold

	// Frame: read flag, address, data, each bit held well past three cycles
	task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] data);
		logic [15:0] bits;
		bits = {rd, addr, data};
		@(posedge clock_in);
		serial_clock_out <= polarity;
		hold(4);
		serial_enable_out <= 1'b1;
		for (int i = 15; i >= 0; i--) begin
			host_oe_n_out <= rd && i < 8;
			host_data_out <= bits[i];
			hold(4);
			if (rd && i < 8) begin
				read_byte[i] = line_in;
			end
			serial_clock_out <= !polarity;
			hold(1);
			// Let go once the last header bit is taken, before the device drives
			if (rd && i == 8) begin
				host_oe_n_out <= 1'b1;
			end
			hold(3);
			serial_clock_out <= polarity;
		end
		hold(4);
		serial_enable_out <= 1'b0;
		host_oe_n_out <= 1'b1;
		hold(4);
	endtask : frame
endmodule : serial_host

// ===== bench/test_motor_driver_control_registers.sv
`timescale 1ns/1ns
`include "motor_regs_cfg.svh"

module test_motor_driver_control_registers;
	import motor_regs_pkg::*;
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic sclk, sen, host_data, host_oe_n, line, last_line = 1'b0;
	logic dev_data, dev_oe_n, shock_sense = 1'b0, shock, negreg, overtemp, supply_comp;
	logic spin, supply_clk, conv_clk, gain, start, scaling, done = 1'b0;
	logic [3:0] mask;
	logic [4:0] window, torque;
	logic [5:0] position;
	logic [9:0] conv_data = 10'h000;
	logic [14:0] dac;
	reg_byte_type amplitude, test_byte;
	conv_channel_type channel;
	int miscompares = 0;
	int check_count = 0;
	int starts = 0;

	always #4 clock_in = !clock_in;
	// Released line shows a changing pattern, never a held value
	assign line = !dev_oe_n ? dev_data : (!host_oe_n ? host_data : !last_line);
	always @(posedge clock_in) last_line <= line;
	always @(posedge clock_in) if (start === 1'b1) starts <= starts + 1;

	motor_regs dut (.clock_in(clock_in), .reset_in(reset_in), .serial_clock_in(sclk),
		.serial_enable_in(sen), .serial_data_in(line), .serial_data_out(dev_data),
		.serial_data_oe_n_out(dev_oe_n), .shock_sense_in(shock_sense), .shock_out(shock),
		.negative_regulator_enable_out(negreg), .overtemp_shutdown_enable_out(overtemp),
		.zero_crossing_mask_out(mask), .zero_crossing_window_out(window),
		.spindle_clock_en_out(spin), .supply_monitor_clock_en_out(supply_clk),
		.converter_clock_en_out(conv_clk), .torque_phase_shift_out(torque),
		.supply_compensation_enable_out(supply_comp), .sample_position_out(position),
		.amplitude_factor_out(amplitude), .voice_coil_dac_out(dac),
		.sense_gain_select_out(gain), .conversion_start_out(start),
		.conversion_channel_select_out(channel), .input_scaling_select_out(scaling),
		.conversion_done_in(done), .conversion_data_in(conv_data),
		.factory_test_out(test_byte));

	serial_host host (.clock_in(clock_in), .serial_clock_out(sclk), .serial_enable_out(sen),
		.host_data_out(host_data), .host_oe_n_out(host_oe_n), .line_in(line));

	task automatic compare_value(input logic [14:0] got, input logic [14:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
		end
	endtask : compare_value

	// Four-state arguments so an unknown enable count cannot pass as zero
	task automatic compare_pulses(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %0d pulses, wanted %0d", $time, got, exp);
		end
	endtask : compare_pulses

	task automatic check_read(input logic [6:0] addr, input logic [7:0] exp);
		host.frame(1'b1, addr, 8'h00);
		compare_value(host.read_byte, exp);
	endtask : check_read

	task automatic test_registers();
		logic [6:0] a [7] = '{`ADDR_SHOCK_REG, `ADDR_CLOCK_WIN, `ADDR_PHASE_CTL,
			`ADDR_AMPLITUDE, `ADDR_DAC_HIGH, `ADDR_DAC_LOW, `ADDR_TEST};
		logic [7:0] d [7] = '{8'h36, 8'ha9, 8'h33, 8'hc5, 8'hda, 8'h3c, 8'h96};
		foreach (a[i]) host.frame(1'b0, a[i], d[i]);
		foreach (a[i]) check_read(a[i], d[i]);
		host.frame(1'b0, `ADDR_RESULT, 8'hff);
		check_read(`ADDR_RESULT, 8'h00);
		check_read(`ADDR_SPARE_0D, 8'h00);
		compare_value(negreg, 1'b1);
		compare_value(overtemp, 1'b1);
		compare_value(mask, 4'h6);
		compare_value(window, 5'h15);
		compare_value(torque, 5'h13);
		compare_value(supply_comp, 1'b1);
		compare_value(amplitude, 8'hc5);
		compare_value(dac, 15'h5a3c);
		compare_value(gain, 1'b1);
		compare_value(test_byte, 8'h96);
	endtask : test_registers

	task automatic test_clocks();
		logic [15:0] sp, su, cv;
		for (int code = 0; code < 4; code++) begin
			host.frame(1'b0, `ADDR_CLOCK_WIN, {5'h15, 2'(code), code == 0});
			sp = 0;
			su = 0;
			cv = 0;
			repeat (64) begin
				@(posedge clock_in);
				#1;
				sp += spin;
				su += supply_clk;
				cv += conv_clk;
			end
			compare_pulses(sp, code == 0 ? 64 : 32);
			compare_pulses(su, code == 0 ? 16 : 8);
			compare_pulses(cv, code == 0 ? 0 : 8 << code);
		end
	endtask : test_clocks

	task automatic test_sample();
		host.frame(1'b0, `ADDR_PHASE_CTL, 8'h05);
		host.frame(1'b0, `ADDR_PHASE_CTL, 8'h85);
		compare_value(position, 6'h05);
		host.frame(1'b0, `ADDR_PHASE_CTL, 8'h45);
		compare_value(position, 6'h06);
		host.frame(1'b0, `ADDR_PHASE_CTL, 8'h45);
		compare_value(position, 6'h06);
	endtask : test_sample

	task automatic test_conversion();
		host.frame(1'b0, `ADDR_CONV_CTL, 8'h0d);
		compare_pulses(starts, 1);
		compare_value(channel, CH_BACK_EMF);
		compare_value(scaling, 1'b1);
		done <= 1'b1;
		conv_data <= 10'h2d5;
		@(posedge clock_in);
		done <= 1'b0;
		check_read(`ADDR_RESULT, 8'hb5);
		check_read(`ADDR_CONV_CTL, 8'h2d);
		host.frame(1'b0, `ADDR_CONV_CTL, 8'h0d);
		compare_pulses(starts, 1);
		host.frame(1'b0, `ADDR_CONV_CTL, 8'h06);
		host.frame(1'b0, `ADDR_CONV_CTL, 8'h07);
		compare_pulses(starts, 2);
		compare_value(channel, CH_AUX);
		compare_value(scaling, 1'b0);
	endtask : test_conversion

	task automatic pulse_shock(input logic exp);
		shock_sense <= 1'b1;
		@(posedge clock_in);
		shock_sense <= 1'b0;
		#1;
		compare_value(shock, 1'b1);
		repeat (4) @(posedge clock_in);
		compare_value(shock, exp);
	endtask : pulse_shock

	task automatic test_shock();
		pulse_shock(1'b0);
		host.frame(1'b0, `ADDR_SHOCK_REG, 8'h37);
		pulse_shock(1'b1);
		host.frame(1'b0, `ADDR_SHOCK_REG, 8'h36);
		host.frame(1'b0, `ADDR_SHOCK_REG, 8'h37);
		compare_value(shock, 1'b0);
	endtask : test_shock

	task automatic test_polarity();
		host.frame(1'b0, `ADDR_SHOCK_REG, 8'hb6);
		host.polarity = 1'b1;
		host.frame(1'b0, `ADDR_AMPLITUDE, 8'h5a);
		check_read(`ADDR_AMPLITUDE, 8'h5a);
		compare_value(amplitude, 8'h5a);
	endtask : test_polarity

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (4) @(posedge clock_in);
		reset_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		test_registers();
		test_clocks();
		test_sample();
		test_conversion();
		test_shock();
		test_polarity();
		give_verdict();
	end

	// Some forty frames of about 150 cycles each fit well inside this span
	initial begin
		repeat (60000) @(posedge clock_in);
		miscompares++;
		give_verdict();
	end
endmodule : test_motor_driver_control_registers

// ===== hdl/motor_regs.sv
`timescale 1ns/1ns
`include "motor_regs_cfg.svh"

module motor_regs #(
	parameter int SAMPLE_COUNT = 48
) (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic serial_clock_in,
	input wire logic serial_enable_in,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe_n_out,
	input wire logic shock_sense_in,
	output logic shock_out,
	output logic negative_regulator_enable_out,
	output logic overtemp_shutdown_enable_out,
	output logic [3:0] zero_crossing_mask_out,
	output logic [4:0] zero_crossing_window_out,
	output logic spindle_clock_en_out,
	output logic supply_monitor_clock_en_out,
	output logic converter_clock_en_out,
	output logic [4:0] torque_phase_shift_out,
	output logic supply_compensation_enable_out,
	output logic [5:0] sample_position_out,
	output motor_regs_pkg::reg_byte_type amplitude_factor_out,
	output logic [14:0] voice_coil_dac_out,
	output logic sense_gain_select_out,
	output logic conversion_start_out,
	output motor_regs_pkg::conv_channel_type conversion_channel_select_out,
	output logic input_scaling_select_out,
	input wire logic conversion_done_in,
	input wire logic [9:0] conversion_data_in,
	output motor_regs_pkg::reg_byte_type factory_test_out
);
	import motor_regs_pkg::*;

	reg_byte_type shock_regulator_control;
	reg_byte_type clock_window_control;
	reg_byte_type phase_sample_control;
	reg_byte_type drive_amplitude;
	reg_byte_type coil_dac_high_gain;
	reg_byte_type coil_dac_low;
	reg_byte_type conversion_result_high;
	reg_byte_type conversion_control;
	reg_byte_type factory_test;
	reg_byte_type read_data;
	reg_byte_type write_data;
	reg_addr_type address;
	logic write_strobe;
	logic shock_latch;
	logic [2:0] div_count;
	logic next_spindle_en;
	logic next_monitor_en;
	logic next_converter_en;
	logic advance_rise;
	logic load_rise;
	logic trigger_rise;
	conv_state_type conv_state;
	conv_channel_type pending_channel;
	conv_channel_type result_channel_tag;

	function automatic logic divider_tick(input logic [2:0] count, input logic [2:0] last);
		divider_tick = (count & last) == last;
	endfunction : divider_tick

	function automatic logic [5:0] position_step(input logic [5:0] pos);
		if (pos >= 6'(SAMPLE_COUNT - 1)) begin
			position_step = 6'h00;
		end else begin
			position_step = pos + 6'h01;
		end
	endfunction : position_step

	function automatic logic write_hits(input logic strobe, input reg_addr_type addr,
		input reg_addr_type target);
		write_hits = strobe && addr == target;
	endfunction : write_hits

	serial_frame_port port (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.serial_clock_in(serial_clock_in),
		.serial_enable_in(serial_enable_in),
		.serial_data_in(serial_data_in),
		.invert_clock_in(shock_regulator_control[`BIT_CLK_POL]),
		.serial_data_out(serial_data_out),
		.serial_data_oe_n_out(serial_data_oe_n_out),
		.write_strobe_out(write_strobe),
		.address_out(address),
		.write_data_out(write_data),
		.read_data_in(read_data)
	);

	// Register writes; 0Bh, 0Dh, 0Eh and unknown addresses are ignored
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			shock_regulator_control <= `RESET_BYTE;
			clock_window_control <= `RESET_BYTE;
			phase_sample_control <= `RESET_BYTE;
			drive_amplitude <= `RESET_BYTE;
			coil_dac_high_gain <= `RESET_BYTE;
			coil_dac_low <= `RESET_BYTE;
			conversion_control <= `RESET_BYTE;
			factory_test <= `RESET_BYTE;
		end else if (write_strobe) begin
			case (address)
				`ADDR_SHOCK_REG: shock_regulator_control <= write_data;
				`ADDR_CLOCK_WIN: clock_window_control <= write_data;
				`ADDR_PHASE_CTL: phase_sample_control <= write_data;
				`ADDR_AMPLITUDE: drive_amplitude <= write_data;
				`ADDR_DAC_HIGH: coil_dac_high_gain <= write_data;
				`ADDR_DAC_LOW: coil_dac_low <= write_data;
				`ADDR_CONV_CTL: conversion_control <= write_data & `CONV_CTL_WRITABLE;
				`ADDR_TEST: factory_test <= write_data;
				default: ;
			endcase
		end
	end

	always_comb begin
		case (address)
			`ADDR_SHOCK_REG: read_data = shock_regulator_control;
			`ADDR_CLOCK_WIN: read_data = clock_window_control;
			`ADDR_PHASE_CTL: read_data = phase_sample_control;
			`ADDR_AMPLITUDE: read_data = drive_amplitude;
			`ADDR_DAC_HIGH: read_data = coil_dac_high_gain;
			`ADDR_DAC_LOW: read_data = coil_dac_low;
			`ADDR_RESULT: read_data = conversion_result_high;
			`ADDR_CONV_CTL: read_data = {2'b00, result_channel_tag, conversion_control[3:0]};
			`ADDR_TEST: read_data = factory_test;
			default: read_data = `RESET_BYTE;
		endcase
	end

	// Edge commands compare the new byte against the stored one
	assign advance_rise = write_hits(write_strobe, address, `ADDR_PHASE_CTL)
		&& write_data[`BIT_ADVANCE] && !phase_sample_control[`BIT_ADVANCE];
	assign load_rise = write_hits(write_strobe, address, `ADDR_PHASE_CTL)
		&& write_data[`BIT_LOAD] && !phase_sample_control[`BIT_LOAD];
	assign trigger_rise = write_hits(write_strobe, address, `ADDR_CONV_CTL)
		&& write_data[`BIT_CONV_TRIG] && !conversion_control[`BIT_CONV_TRIG];

	// Writing the enable low drops the latch, so 1, 0, 1 re-arms it
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			shock_latch <= 1'b0;
			shock_out <= 1'b0;
		end else begin
			if (!shock_regulator_control[`BIT_SHOCK_EN]) begin
				shock_latch <= 1'b0;
			end else if (shock_sense_in) begin
				shock_latch <= 1'b1;
			end
			shock_out <= shock_regulator_control[`BIT_SHOCK_EN]
				? (shock_latch | shock_sense_in) : shock_sense_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			negative_regulator_enable_out <= 1'b0;
			overtemp_shutdown_enable_out <= 1'b0;
			zero_crossing_mask_out <= 4'h0;
			zero_crossing_window_out <= 5'h00;
			torque_phase_shift_out <= 5'h00;
			supply_compensation_enable_out <= 1'b0;
			amplitude_factor_out <= `RESET_BYTE;
			voice_coil_dac_out <= 15'h0000;
			sense_gain_select_out <= 1'b0;
			conversion_channel_select_out <= CH_CURRENT;
			input_scaling_select_out <= 1'b0;
			factory_test_out <= `RESET_BYTE;
		end else begin
			negative_regulator_enable_out <= shock_regulator_control[`BIT_NEG_REG];
			overtemp_shutdown_enable_out <= shock_regulator_control[`BIT_OVERTEMP];
			zero_crossing_mask_out <= shock_regulator_control[`MASK_MSB:`MASK_LSB];
			zero_crossing_window_out <= clock_window_control[`WIN_MSB:`WIN_LSB];
			torque_phase_shift_out <= phase_sample_control[`TPS_MSB:0];
			supply_compensation_enable_out <= phase_sample_control[`BIT_SUPPLY_COMP];
			amplitude_factor_out <= drive_amplitude;
			voice_coil_dac_out <= {coil_dac_high_gain[`DAC_HIGH_MSB:0], coil_dac_low};
			sense_gain_select_out <= coil_dac_high_gain[`BIT_GAIN];
			conversion_channel_select_out <= conv_channel_type'(
				conversion_control[`CONV_CH_MSB:`CONV_CH_LSB]);
			input_scaling_select_out <= conversion_control[`BIT_SCALING];
			factory_test_out <= factory_test;
		end
	end

	// Free-running divider; every slower rate is a one-cycle enable
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			div_count <= 3'h0;
		end else begin
			div_count <= div_count + 3'h1;
		end
	end

	always_comb begin
		next_spindle_en = clock_window_control[`BIT_PRESCALE]
			|| divider_tick(div_count, `DIV2_LAST);
		next_monitor_en = clock_window_control[`BIT_PRESCALE]
			? divider_tick(div_count, `DIV4_LAST) : divider_tick(div_count, `DIV8_LAST);
		unique case (conv_clock_type'(clock_window_control[`CONV_CLK_MSB:`CONV_CLK_LSB]))
			CONV_SLEEP: next_converter_en = 1'b0;
			CONV_DIV4: next_converter_en = divider_tick(div_count, `DIV4_LAST);
			CONV_DIV2: next_converter_en = divider_tick(div_count, `DIV2_LAST);
			CONV_FULL: next_converter_en = 1'b1;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			spindle_clock_en_out <= 1'b0;
			supply_monitor_clock_en_out <= 1'b0;
			converter_clock_en_out <= 1'b0;
		end else begin
			spindle_clock_en_out <= next_spindle_en;
			supply_monitor_clock_en_out <= next_monitor_en;
			converter_clock_en_out <= next_converter_en;
		end
	end

	// Load wins when both edges arrive in the same write
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			sample_position_out <= 6'h00;
		end else if (load_rise) begin
			sample_position_out <= {1'b0, write_data[`TPS_MSB:0]};
		end else if (advance_rise) begin
			sample_position_out <= position_step(sample_position_out);
		end
	end

	// A new trigger restarts even while busy; the result keeps the newest channel
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			conv_state <= CONV_IDLE;
			pending_channel <= CH_CURRENT;
			conversion_start_out <= 1'b0;
		end else begin
			conversion_start_out <= trigger_rise;
			if (trigger_rise) begin
				conv_state <= CONV_BUSY;
				pending_channel <= conv_channel_type'(write_data[`CONV_CH_MSB:`CONV_CH_LSB]);
			end else begin
				unique case (conv_state)
					CONV_IDLE: conv_state <= CONV_IDLE;
					CONV_BUSY: if (conversion_done_in) begin
						conv_state <= CONV_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			conversion_result_high <= `RESET_BYTE;
			result_channel_tag <= CH_CURRENT;
		end else if (conv_state == CONV_BUSY && conversion_done_in && !trigger_rise) begin
			conversion_result_high <= conversion_data_in[9:2];
			result_channel_tag <= pending_channel;
		end
	end

	default clocking assert_clock @(posedge clock_in);
	endclocking
	default disable iff (reset_in);

	AST_SHOCK_HOLDS: assert property (
		shock_regulator_control[`BIT_SHOCK_EN] && shock_sense_in
		&& !write_hits(write_strobe, address, `ADDR_SHOCK_REG)
		|=> ##1 shock_out)
		else $error("Latched shock not held");

	AST_SHOCK_FOLLOWS: assert property (
		!shock_regulator_control[`BIT_SHOCK_EN] [*2] |-> shock_out == $past(shock_sense_in))
		else $error("Unlatched shock output does not follow sensor");

	AST_REGULATOR_WRITE: assert property (
		write_hits(write_strobe, address, `ADDR_SHOCK_REG)
		|=> ##1 negative_regulator_enable_out == $past(write_data[`BIT_NEG_REG], 2)
		&& overtemp_shutdown_enable_out == $past(write_data[`BIT_OVERTEMP], 2))
		else $error("Regulator or shutdown enable not taken from write");

	AST_SPINDLE_HALF: assert property (
		!clock_window_control[`BIT_PRESCALE] [*3]
		|-> spindle_clock_en_out != $past(spindle_clock_en_out))
		else $error("Spindle enable not at half rate");

	AST_MONITOR_DIV: assert property (
		supply_monitor_clock_en_out |-> $past(clock_window_control[`BIT_PRESCALE])
		? divider_tick($past(div_count), `DIV4_LAST)
		: divider_tick($past(div_count), `DIV8_LAST))
		else $error("Supply monitor enable at wrong rate");

	AST_CONVERTER_SLEEP: assert property (
		$past(clock_window_control[`CONV_CLK_MSB:`CONV_CLK_LSB]) == CONV_SLEEP
		|-> !converter_clock_en_out)
		else $error("Converter clock runs in sleep");

	AST_ADVANCE_STEP: assert property (
		advance_rise && !load_rise
		|=> sample_position_out == position_step($past(sample_position_out)))
		else $error("Advance did not step position by one");

	AST_STATIC_ADVANCE: assert property (
		!advance_rise && !load_rise |=> $stable(sample_position_out))
		else $error("Sample position moved without a command");

	AST_LOAD_COPY: assert property (
		load_rise |=> sample_position_out == {1'b0, $past(write_data[`TPS_MSB:0])})
		else $error("Load did not copy the phase shift");

	AST_START_PULSE: assert property (
		conversion_start_out |-> $past(trigger_rise) ##1 !conversion_start_out)
		else $error("Conversion start without a rising trigger");

	AST_RESULT_CAPTURE: assert property (
		conv_state == CONV_BUSY && conversion_done_in && !trigger_rise
		|=> conversion_result_high == $past(conversion_data_in[9:2])
		&& result_channel_tag == $past(pending_channel))
		else $error("Conversion result or channel tag not captured");

	AST_DAC_CODE: assert property (
		$stable(coil_dac_low) && $stable(coil_dac_high_gain)
		|=> voice_coil_dac_out == {$past(coil_dac_high_gain[`DAC_HIGH_MSB:0]),
		$past(coil_dac_low)})
		else $error("Voice-coil code not assembled from both registers");

	COVER_SHOCK_LATCHED: cover property (
		shock_regulator_control[`BIT_SHOCK_EN] && shock_sense_in ##1 !shock_sense_in [*3]);
	COVER_CONVERSION: cover property (trigger_rise ##[1:50] conversion_done_in);
	COVER_LOAD_ADVANCE: cover property (load_rise ##[1:200] advance_rise);
	COVER_READ_FRAME: cover property (!serial_data_oe_n_out [*8]);
endmodule : motor_regs

// ===== hdl/motor_regs_cfg.svh
`ifndef MOTOR_REGS_CFG_SVH
`define MOTOR_REGS_CFG_SVH

// Register addresses
`define ADDR_SHOCK_REG 7'h05
`define ADDR_CLOCK_WIN 7'h06
`define ADDR_PHASE_CTL 7'h07
`define ADDR_AMPLITUDE 7'h08
`define ADDR_DAC_HIGH 7'h09
`define ADDR_DAC_LOW 7'h0a
`define ADDR_RESULT 7'h0b
`define ADDR_CONV_CTL 7'h0c
`define ADDR_SPARE_0D 7'h0d
`define ADDR_SPARE_0E 7'h0e
`define ADDR_TEST 7'h0f

// Field positions
`define BIT_SHOCK_EN 0
`define BIT_NEG_REG 1
`define BIT_OVERTEMP 2
`define MASK_LSB 3
`define MASK_MSB 6
`define BIT_CLK_POL 7
`define BIT_PRESCALE 0
`define CONV_CLK_LSB 1
`define CONV_CLK_MSB 2
`define WIN_LSB 3
`define WIN_MSB 7
`define TPS_MSB 4
`define BIT_SUPPLY_COMP 5
`define BIT_ADVANCE 6
`define BIT_LOAD 7
`define BIT_GAIN 7
`define DAC_HIGH_MSB 6
`define BIT_CONV_TRIG 0
`define CONV_CH_LSB 1
`define CONV_CH_MSB 2
`define BIT_SCALING 3
`define CONV_CTL_WRITABLE 8'h0f

// Reset values
`define RESET_BYTE 8'h00

// Clock divider terminal counts
`define DIV2_LAST 3'h1
`define DIV4_LAST 3'h3
`define DIV8_LAST 3'h7

// Serial frame: read flag, 7 address bits, 8 data bits
`define HEADER_BITS 5'h08
`define FRAME_BITS 5'h10
`define COUNT_STEP 5'h01

`endif

// ===== hdl/motor_regs_pkg.sv
package motor_regs_pkg;
	typedef logic [7:0] reg_byte_type;
	typedef logic [6:0] reg_addr_type;
	typedef enum logic [1:0] {CH_CURRENT, CH_VOLTAGE, CH_BACK_EMF, CH_AUX} conv_channel_type;
	typedef enum logic [1:0] {CONV_SLEEP, CONV_DIV4, CONV_DIV2, CONV_FULL} conv_clock_type;
	typedef enum {CONV_IDLE, CONV_BUSY} conv_state_type;
endpackage : motor_regs_pkg

// ===== hdl/serial_frame_port.sv
`timescale 1ns/1ns
`include "motor_regs_cfg.svh"

module serial_frame_port (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic serial_clock_in,
	input wire logic serial_enable_in,
	input wire logic serial_data_in,
	input wire logic invert_clock_in,
	output logic serial_data_out,
	output logic serial_data_oe_n_out,
	output logic write_strobe_out,
	output motor_regs_pkg::reg_addr_type address_out,
	output motor_regs_pkg::reg_byte_type write_data_out,
	input motor_regs_pkg::reg_byte_type read_data_in
);
	import motor_regs_pkg::*;

	logic clock_prev;
	logic active_edge;
	logic [4:0] bit_count;
	logic [6:0] shift_in;
	reg_byte_type shift_out;
	logic is_read;
	logic read_loaded;

	// Polarity picks which serial clock edge samples the data line
	assign active_edge = invert_clock_in ? (clock_prev & ~serial_clock_in)
		: (~clock_prev & serial_clock_in);

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			clock_prev <= 1'b0;
		end else begin
			clock_prev <= serial_clock_in;
		end
	end

	// Frame resets whenever enable drops, so a broken frame never writes
	always_ff @(posedge clock_in) begin
		if (reset_in || !serial_enable_in) begin
			bit_count <= 5'h00;
			shift_in <= 7'h00;
		end else if (active_edge && bit_count != `FRAME_BITS) begin
			shift_in <= {shift_in[5:0], serial_data_in};
			bit_count <= bit_count + `COUNT_STEP;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			address_out <= 7'h00;
			is_read <= 1'b0;
		end else if (serial_enable_in && active_edge && bit_count == `HEADER_BITS - `COUNT_STEP) begin
			address_out <= {shift_in[5:0], serial_data_in};
			is_read <= shift_in[6];
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			write_strobe_out <= 1'b0;
			write_data_out <= `RESET_BYTE;
		end else begin
			write_strobe_out <= serial_enable_in && active_edge && !is_read
				&& bit_count == `FRAME_BITS - `COUNT_STEP;
			if (serial_enable_in && active_edge && bit_count == `FRAME_BITS - `COUNT_STEP) begin
				write_data_out <= {shift_in, serial_data_in};
			end
		end
	end

	// Read data loads one cycle after the header, then shifts per edge
	always_ff @(posedge clock_in) begin
		if (reset_in || !serial_enable_in) begin
			shift_out <= `RESET_BYTE;
			read_loaded <= 1'b0;
		end else if (is_read && bit_count == `HEADER_BITS && !read_loaded) begin
			shift_out <= read_data_in;
			read_loaded <= 1'b1;
		end else if (read_loaded && active_edge) begin
			shift_out <= {shift_out[6:0], 1'b0};
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			serial_data_out <= 1'b0;
			serial_data_oe_n_out <= 1'b1;
		end else begin
			serial_data_out <= shift_out[7];
			serial_data_oe_n_out <= !(serial_enable_in && read_loaded);
		end
	end
endmodule : serial_frame_port
